/* File: sim/aiq_converter_model.sv */
// Behavioural converter and level comparator facing the sequencer.
// Assumes the bench sets the conversion time and which channels sit above the level.
`timescale 1ns/1ps
`default_nettype none
module aiq_converter_model (
    // Clock.
    input wire logic                      mclk,
    // Converter link.
    input wire aiq_pkg::aiq_conv_t        conv,
    output logic                          convDone,
    output logic [aiq_pkg::AIQ_SMP_W-1:0] convData,
    output logic                          levelAbove,
    // Bench controls.
    input wire logic [7:0]                delay,
    input wire logic [15:0]               aboveMap
);
    import aiq_pkg::*;
    logic [7:0] waitCnt;
    logic       busy;
    logic [7:0] chan;
    initial begin
        convDone = 1'b0;
        convData = 12'h5A5;
        levelAbove = 1'b0;
        waitCnt = 8'h00;
        busy = 1'b0;
        chan = 8'h00;
    end
    always @(posedge mclk) begin
        convDone <= 1'b0;
        if (conv.start) begin
            busy <= 1'b1;
            waitCnt <= delay;
            chan <= conv.chan;
        end else if (busy && waitCnt == 8'h00) begin
            busy <= 1'b0;
            convDone <= 1'b1;
            convData <= {4'hA, chan};
            levelAbove <= aboveMap[chan[3:0]];
        end else begin
            if (busy) waitCnt <= waitCnt - 8'h01;
            // Result lines carry nothing valid outside the done cycle.
            convData <= ~convData;
            levelAbove <= ~levelAbove;
        end
    end
endmodule : aiq_converter_model
`default_nettype wire

/* File: sim/aiq_sequencer_bench.sv */
// Self-checking bench for the acquisition sequencer.
// Assumes the converter model answers each start and the FIFO is eight words deep.
`timescale 1ns/1ps
`default_nettype none
module aiq_sequencer_bench;
    import aiq_pkg::*;
    logic        mclk, resetn, extPace, extTrig, aoPace, rateOut, convDone, levelAbove;
    logic        trigLevelOwn;
    aiq_bus_t    bus;
    aiq_conv_t   conv;
    logic [31:0] rdata, rv;
    logic [11:0] convData, trigLevelNeg;
    logic [7:0]  delay;
    logic [15:0] aboveMap;
    int          fails, check_count, gap;
    localparam logic [3:0]  RST_ADDR [5] = '{AIQ_REG_CTRL, AIQ_REG_RATE, AIQ_REG_COUNT,
                                             AIQ_REG_STATUS, 4'hF};
    localparam logic [31:0] RST_VAL [5] = '{32'h0, 32'h50, 32'h1, 32'h8, 32'h0};
    localparam logic [31:0] TRIG_CTRL [2] = '{32'h19, 32'h58};
    localparam logic [31:0] RATE_SET [2] = '{32'h0A, 32'hA0};
    localparam int RATE_GAP [2] = '{int'(AIQ_MIN_DIV) * AIQ_BASE_DIV, 160 * AIQ_BASE_DIV};
    localparam logic [7:0]  SCAN_SEQ [5] = '{8'h0, 8'h1, 8'h2, 8'h0, 8'h1};
    localparam logic [7:0]  TRIG_SEQ [4] = '{8'h2, 8'h3, 8'h0, 8'h1};
    ////////////////////////////////////////////////////////////////////////////
    aiq_sequencer #(.FIFO_AW(3)) u_dut (.mclk(mclk), .resetn(resetn), .bus(bus), .rdata(rdata),
        .extPace(extPace), .extTrig(extTrig), .aoPace(aoPace), .rateOut(rateOut), .conv(conv),
        .convDone(convDone), .convData(convData), .levelAbove(levelAbove),
        .trigLevelNeg(trigLevelNeg), .trigLevelOwn(trigLevelOwn));
    aiq_converter_model u_model (.mclk(mclk), .conv(conv), .convDone(convDone),
        .convData(convData), .levelAbove(levelAbove), .delay(delay), .aboveMap(aboveMap));
    initial begin
        mclk = 1'b0;
        aoPace = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) aoPace <= ~aoPace;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 rv = rdata;
    endtask : rd
    task automatic status(input logic [1:0] s, input logic e);
        rd(AIQ_REG_STATUS);
        check("state", 32'(s), 32'(rv[1:0]));
        check("empty", 32'(e), 32'(rv[3]));
    endtask : status
    task automatic pop(input logic [7:0] ch);
        rd(AIQ_REG_FIFO);
        check("fifo word", {20'h0, 4'hA, ch}, rv);
    endtask : pop
    task automatic pace(input int n);
        repeat (n) begin
            @(posedge mclk);
            extPace <= 1'b1;
            @(posedge mclk);
            extPace <= 1'b0;
            repeat (30) @(posedge mclk);
        end
    endtask : pace
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic waitStart(output int n);
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (conv.start !== 1'b1 && n < 4000);
        if (n >= 4000) begin
            fails++;
            $display("ERROR conv start expected pulse seen none");
            wrap_up();
        end
    endtask : waitStart
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        bus = '0;
        extPace = 1'b0;
        extTrig = 1'b0;
        delay = 8'h0C;
        aboveMap = 16'h0000;
        fails = 0;
        check_count = 0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        foreach (RST_ADDR[i]) begin
            rd(RST_ADDR[i]);
            check("reset value", RST_VAL[i], rv);
        end
        $display("test reset finished");
        wr(AIQ_REG_SCAN, 32'h2);
        wr(AIQ_REG_COUNT, 32'h5);
        wr(AIQ_REG_CTRL, 32'h2C9C);
        wr(AIQ_REG_CMD, 32'h1);
        pace(7);
        status(2'h0, 1'b0);
        foreach (SCAN_SEQ[i]) pop(SCAN_SEQ[i]);
        status(2'h0, 1'b1);
        $display("test scan count finished");
        delay = 8'h01;
        wr(AIQ_REG_SCAN, 32'h0);
        for (int m = 0; m < 2; m++) begin
            @(posedge mclk) extTrig <= m[0];
            wr(AIQ_REG_COUNT, 32'h3);
            wr(AIQ_REG_CTRL, TRIG_CTRL[m]);
            wr(AIQ_REG_CMD, 32'h1);
            pace(2);
            status(2'h1, 1'b1);
            @(posedge mclk) extTrig <= ~m[0];
            pace(3);
            status(m[0] ? 2'h3 : 2'h0, 1'b0);
            wr(AIQ_REG_CMD, 32'h2);
            status(2'h0, 1'b0);
            repeat (3) pop(8'h00);
        end
        $display("test digital trigger finished");
        wr(AIQ_REG_COUNT, 32'h2);
        wr(AIQ_REG_CTRL, 32'h1A);
        wr(AIQ_REG_CMD, 32'h1);
        pace(4);
        status(2'h3, 1'b0);
        @(posedge mclk) extTrig <= 1'b1;
        pace(4);
        status(2'h0, 1'b0);
        repeat (6) pop(8'h00);
        status(2'h0, 1'b1);
        $display("test post trigger finished");
        wr(AIQ_REG_SCAN, 32'h3);
        wr(AIQ_REG_TRIG, 32'h0100_0002);
        wr(AIQ_REG_COUNT, 32'h4);
        wr(AIQ_REG_CTRL, 32'h39);
        wr(AIQ_REG_CMD, 32'h1);
        pace(4);
        status(2'h1, 1'b1);
        check("level owner", 32'h1, 32'(trigLevelOwn));
        check("level code", 32'hF00, 32'(trigLevelNeg));
        @(posedge mclk) aboveMap <= 16'hFFFF;
        pace(5);
        status(2'h0, 1'b0);
        foreach (TRIG_SEQ[i]) pop(TRIG_SEQ[i]);
        $display("test analog trigger finished");
        wr(AIQ_REG_SCAN, 32'h0);
        wr(AIQ_REG_CTRL, 32'h1B);
        wr(AIQ_REG_CMD, 32'h1);
        pace(10);
        rd(AIQ_REG_STATUS);
        check("full and overflow", 32'h3, 32'(rv[5:4]));
        wr(AIQ_REG_CMD, 32'h2);
        repeat (8) pop(8'h00);
        status(2'h0, 1'b1);
        check("level owner", 32'h0, 32'(trigLevelOwn));
        $display("test fifo fill finished");
        wr(AIQ_REG_RATE, 32'hFFFFFF);
        rd(AIQ_REG_RATE);
        check("rate width", 32'h00FFFFFF, rv);
        for (int i = 0; i < 2; i++) begin
            wr(AIQ_REG_RATE, RATE_SET[i]);
            wr(AIQ_REG_CTRL, 32'h3);
            wr(AIQ_REG_CMD, 32'h1);
            waitStart(gap);
            waitStart(gap);
            check("pacing gap", 32'(RATE_GAP[i]), 32'(gap));
            wr(AIQ_REG_CMD, 32'h2);
        end
        $display("test rate generator finished");
        wrap_up();
    end
endmodule : aiq_sequencer_bench
`default_nettype wire

/* File: sim/aiq_sequencer_properties.sv */
// Port checker for the acquisition sequencer.
// Assumes one clock; control and scan words are shadowed from register writes.
`timescale 1ns/1ps
`default_nettype none
module aiq_sequencer_properties (
    // Clock and reset.
    input wire logic               mclk,
    input wire logic               resetn,
    // Register port and pins.
    input wire aiq_pkg::aiq_bus_t  bus,
    input wire logic [31:0]        rdata,
    input wire logic               aoPace,
    input wire logic               rateOut,
    input wire aiq_pkg::aiq_conv_t conv,
    input wire logic               convDone,
    input wire logic               trigLevelOwn
);
    import aiq_pkg::*;
    logic [31:0] ctrl_r;
    logic [7:0]  last_r;
    logic        busy_r;
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= 32'h0;
            last_r <= 8'h00;
            busy_r <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == AIQ_REG_CTRL) ctrl_r <= bus.wdata;
            if (bus.wr && bus.addr == AIQ_REG_SCAN) last_r <= bus.wdata[7:0];
            if (conv.start) busy_r <= 1'b1;
            else if (convDone) busy_r <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence ctrlWrite;
        bus.wr && bus.addr == AIQ_REG_CTRL;
    endsequence
    sequence convEnd;
        busy_r && convDone;
    endsequence
    a_start_pulse: assert property (conv.start |=> !conv.start)
        else $error("start pulse longer than one cycle");
    a_one_pending: assert property (conv.start |-> !busy_r)
        else $error("start while a conversion is pending");
    a_chan_hold: assert property (busy_r && !convDone |=> $stable(conv.chan))
        else $error("channel moved during a conversion");
    a_scan_step: assert property (convEnd ##0 (ctrl_r[4] && !ctrl_r[5]) |=>
        conv.chan == (($past(conv.chan) >= last_r) ? 8'h00 : $past(conv.chan) + 8'h01))
        else $error("scanner stepped to a wrong channel");
    a_read_idle: assert property (!bus.rd |=> rdata == 32'h0)
        else $error("read data outside the read answer cycle");
    a_zero_mode: assert property (conv.start |-> conv.autoZero == ctrl_r[7])
        else $error("auto zero differs from control");
    a_gain_range: assert property (conv.start |-> {conv.range, conv.gain, conv.diff} == ctrl_r[12:8])
        else $error("gain range or input mode differs from control");
    a_rate_select: assert property (ctrl_r[13] && !(bus.wr && bus.addr == AIQ_REG_CTRL)
        |=> rateOut == $past(aoPace))
        else $error("rate output not following output pacing");
    a_level_own: assert property (ctrlWrite |-> ##2 trigLevelOwn == ctrl_r[5])
        else $error("level output reservation differs from control");
endmodule : aiq_sequencer_properties
bind aiq_sequencer aiq_sequencer_properties u_props (.mclk(mclk), .resetn(resetn), .bus(bus),
    .rdata(rdata), .aoPace(aoPace), .rateOut(rateOut), .conv(conv), .convDone(convDone),
    .trigLevelOwn(trigLevelOwn));
`default_nettype wire

/* File: verilog/aiq_pkg.sv */
// Package for the analog input acquisition sequencer.
// Assumes one 125 MHz clock and a plain register port from the host side.
package aiq_pkg;

    localparam int AIQ_CLK_HZ       = 125000000;
    localparam int AIQ_BASE_HZ      = 8000000;
    localparam int AIQ_BASE_PERIOD_NS = 125;
    // Cycles of mclk per base tick, rounded down so the tick is never slow.
    localparam int AIQ_BASE_DIV     = AIQ_CLK_HZ / AIQ_BASE_HZ;
    localparam int AIQ_MAX_RATE_HZ  = 100000;
    // Smallest divisor: the top rate at the nominal base, about 104167 Hz at the 120 ns tick.
    localparam logic [23:0] AIQ_MIN_DIV = 24'(AIQ_BASE_HZ / AIQ_MAX_RATE_HZ);

    localparam int AIQ_RATE_W   = 24;
    localparam int AIQ_SMP_W    = 12;
    localparam int AIQ_CHAN_W   = 8;
    localparam int AIQ_CNT_W    = 24;
    localparam int AIQ_FIFO_AW  = 9;

    // Register offsets.
    localparam logic [3:0] AIQ_REG_CTRL    = 4'h0;
    localparam logic [3:0] AIQ_REG_RATE    = 4'h1;
    localparam logic [3:0] AIQ_REG_COUNT   = 4'h2;
    localparam logic [3:0] AIQ_REG_SCAN    = 4'h3;
    localparam logic [3:0] AIQ_REG_TRIG    = 4'h4;
    localparam logic [3:0] AIQ_REG_CMD     = 4'h5;
    localparam logic [3:0] AIQ_REG_STATUS  = 4'h6;
    localparam logic [3:0] AIQ_REG_FIFO    = 4'h7;
    localparam logic [3:0] AIQ_REG_REMAIN  = 4'h8;

    // Control field positions.
    localparam int AIQ_CTRL_MODE_LSB  = 0;
    localparam int AIQ_CTRL_EXTPACE   = 3;
    localparam int AIQ_CTRL_SCANEN    = 4;
    localparam int AIQ_CTRL_ANATRIG   = 5;
    localparam int AIQ_CTRL_FALLING   = 6;
    localparam int AIQ_CTRL_AUTOZERO  = 7;
    localparam int AIQ_CTRL_DIFF      = 8;
    localparam int AIQ_CTRL_GAIN_LSB  = 9;
    localparam int AIQ_CTRL_RANGE_LSB = 11;
    localparam int AIQ_CTRL_RGOUTSEL  = 13;
    localparam int AIQ_CMD_START      = 0;
    localparam int AIQ_CMD_STOP       = 1;
    localparam int AIQ_TRIG_LEVEL_LSB = 16;

    localparam logic [31:0] AIQ_CTRL_RESET  = 32'h0000_0000;
    localparam logic [23:0] AIQ_RATE_RESET  = 24'h000050;
    localparam logic [23:0] AIQ_COUNT_RESET = 24'h000001;

    typedef enum logic [2:0] {
        AIQ_TRIG_SWSTOP   = 3'h0,
        AIQ_TRIG_NSAMP    = 3'h1,
        AIQ_SW_POSTTRIG   = 3'h2,
        AIQ_SW_SWSTOP     = 3'h3,
        AIQ_SW_NSAMP      = 3'h4
    } aiq_mode_t;

    typedef enum logic [1:0] {
        AIQ_IDLE = 2'b00,
        AIQ_ARM  = 2'b01,
        AIQ_RUN  = 2'b11,
        AIQ_POST = 2'b10
    } aiq_state_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } aiq_bus_t;

    typedef struct packed {
        logic                  start;
        logic [AIQ_CHAN_W-1:0] chan;
        logic                  autoZero;
        logic                  diff;
        logic [1:0]            gain;
        logic [1:0]            range;
    } aiq_conv_t;

    typedef struct packed {
        aiq_state_t              st;
        logic [31:0]             ctrl;
        logic [AIQ_RATE_W-1:0]   rateDiv;
        logic [AIQ_CNT_W-1:0]    count;
        logic [AIQ_CHAN_W-1:0]   lastChan;
        logic [AIQ_CHAN_W-1:0]   trigChan;
        logic [AIQ_SMP_W-1:0]    trigLevel;
        logic [AIQ_CNT_W-1:0]    remain;
        logic [AIQ_RATE_W-1:0]   rateCnt;
        logic [4:0]              baseCnt;
        logic [AIQ_CHAN_W-1:0]   chan;
        logic                    busy;
        logic                    extPrev;
        logic                    aboveOk;
        logic                    belowOk;
        logic                    overflow;
        logic [AIQ_FIFO_AW:0]    wp;
        logic [AIQ_FIFO_AW:0]    rp;
        logic [31:0]             rdata;
        aiq_conv_t               conv;
        logic                    rgOut;
    } aiq_state_s_t;

    // Returns the channel after cur in a 0..last scan.
    function automatic logic [AIQ_CHAN_W-1:0] aiq_next_chan(
        input logic [AIQ_CHAN_W-1:0] cur, input logic [AIQ_CHAN_W-1:0] last);
        return (cur >= last) ? '0 : cur + 8'h01;
    endfunction : aiq_next_chan

endpackage : aiq_pkg

/* File: verilog/aiq_sequencer.sv */
// Analog input acquisition sequencer: pacing, triggering, scanning and sample FIFO.
// Assumes a converter that pulses done with a 12-bit result and a comparator
// whose output tells whether the active channel is above the trigger level.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - 24-bit rate generator paced from an 8 MHz base tick, 125 ns steps; here the tick is every 15 mclk cycles, 120 ns steps.
// - Pacing spans about 0.477 to 100000 conversions per second; here about 0.497 to 104167.
// - Conversion starts come from the rate generator or external pacing.
// - Five start/stop mode combinations are supported.
// - External trigger detects rising or falling edge as programmed.
// - Analog trigger fires when the channel crosses the level in set direction.
// - Sample counter ends acquisition after the configured count.
// - Post-trigger runs freely until trigger, then takes exactly N more samples.
// - Scanner selects next channel right after current conversion completes.
// - Scanner steps 0 to N then wraps to 0.
// - Scanner supports up to 256 channels.
// - Analog start-on-trigger begins scanning on the trigger channel.
// - Stop-on-trigger analog compare counts only while trigger channel is active.
// - Trigger level is driven negated on analog output 1, reserved meanwhile.
// - Auto-zero grounds converter inputs and disables the multiplexers.
// - Each conversion yields a 12-bit result, at most 100 kHz; here the rate generator paces up to about 104167 Hz.
// - Samples go into a FIFO accepting the full paced rate.
// - Gain 1, 10 or 100 with unipolar or bipolar range selection.
// - Multiplexer runs as 16 single-ended or 8 differential channels.
// - Rate output pin driven by input or output pacing generator, as selected.
module aiq_sequencer #(
    parameter int FIFO_AW = aiq_pkg::AIQ_FIFO_AW
) (
    // Clock and reset.
    input  wire logic                         mclk,
    input  wire logic                         resetn,
    // Register port.
    input  wire aiq_pkg::aiq_bus_t            bus,
    output logic [31:0]                       rdata,
    // External pacing, trigger and output-side pacing.
    input  wire logic                         extPace,
    input  wire logic                         extTrig,
    input  wire logic                         aoPace,
    output logic                              rateOut,
    // Converter side.
    output aiq_pkg::aiq_conv_t                conv,
    input  wire logic                         convDone,
    input  wire logic [aiq_pkg::AIQ_SMP_W-1:0] convData,
    input  wire logic                         levelAbove,
    output logic [11:0]                       trigLevelNeg,
    output logic                              trigLevelOwn
);
    import aiq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and storage.

    logic                 rstMeta_r;
    logic                 rstSync_r;
    logic [AIQ_SMP_W-1:0] fifoMem [0:(1<<FIFO_AW)-1];
    logic [AIQ_SMP_W-1:0] fifoOut_r;
    aiq_state_s_t         s_r;
    aiq_state_s_t         s_nxt;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decode.

    aiq_mode_t            mode;
    logic                 fifoFull;
    logic                 fifoEmpty;
    logic                 fifoPop;
    logic                 fifoPush;
    logic                 baseTick;
    logic                 rateTick;
    logic                 paceTick;
    logic                 extEdge;
    logic                 anaEdge;
    logic                 trigEvt;
    logic                 startsOnTrig;
    logic                 countsN;

    always_comb begin
        mode         = aiq_mode_t'(s_r.ctrl[AIQ_CTRL_MODE_LSB +: 3]);
        fifoFull     = (s_r.wp[FIFO_AW] != s_r.rp[FIFO_AW])
                       && (s_r.wp[FIFO_AW-1:0] == s_r.rp[FIFO_AW-1:0]);
        fifoEmpty    = (s_r.wp == s_r.rp);
        fifoPop      = bus.rd && (bus.addr == AIQ_REG_FIFO) && !fifoEmpty;
        // Samples taken while armed only watch for the trigger and are not stored.
        fifoPush     = convDone && s_r.busy && (s_r.st != AIQ_ARM) && !fifoFull;
        baseTick     = (s_r.baseCnt == 5'(AIQ_BASE_DIV - 1));
        // Divisor count completes once per programmed number of base ticks.
        rateTick     = baseTick && (s_r.rateCnt == '0);
        paceTick     = s_r.ctrl[AIQ_CTRL_EXTPACE] ? extPace : rateTick;
        extEdge      = s_r.ctrl[AIQ_CTRL_FALLING] ? (s_r.extPrev && !extTrig)
                                                  : (!s_r.extPrev && extTrig);
        // Crossing needs the prior side seen on the trigger channel.
        anaEdge      = convDone && (s_r.conv.chan == s_r.trigChan)
                       && (s_r.ctrl[AIQ_CTRL_FALLING] ? (s_r.aboveOk && !levelAbove)
                                                      : (s_r.belowOk && levelAbove));
        trigEvt      = s_r.ctrl[AIQ_CTRL_ANATRIG] ? anaEdge : extEdge;
        startsOnTrig = (mode == AIQ_TRIG_SWSTOP) || (mode == AIQ_TRIG_NSAMP);
        countsN      = (mode == AIQ_TRIG_NSAMP) || (mode == AIQ_SW_NSAMP);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        s_nxt            = s_r;
        s_nxt.conv.start = 1'b0;
        s_nxt.extPrev    = extTrig;
        s_nxt.baseCnt    = baseTick ? '0 : s_r.baseCnt + 5'h01;
        if (rateTick) begin
            s_nxt.rateCnt = s_r.rateDiv - 24'h000001;
        end else if (baseTick) begin
            s_nxt.rateCnt = s_r.rateCnt - 24'h000001;
        end
        s_nxt.rgOut = s_r.ctrl[AIQ_CTRL_RGOUTSEL] ? aoPace : rateTick;
        s_nxt.rdata = 32'h0000_0000;

        // Register writes.
        if (bus.wr) begin
            unique case (bus.addr)
                AIQ_REG_CTRL:  s_nxt.ctrl = bus.wdata;
                AIQ_REG_RATE: begin
                    s_nxt.rateDiv = (bus.wdata[23:0] < AIQ_MIN_DIV)
                                    ? AIQ_MIN_DIV : bus.wdata[23:0];
                    s_nxt.rateCnt = '0;
                end
                AIQ_REG_COUNT: s_nxt.count = bus.wdata[23:0];
                AIQ_REG_SCAN:  s_nxt.lastChan = bus.wdata[7:0];
                AIQ_REG_TRIG: begin
                    s_nxt.trigChan  = bus.wdata[7:0];
                    s_nxt.trigLevel = 12'h000 - bus.wdata[AIQ_TRIG_LEVEL_LSB +: 12];
                end
                default: ;
            endcase
        end

        // Converter configuration follows control bits.
        s_nxt.conv.autoZero = s_r.ctrl[AIQ_CTRL_AUTOZERO];
        s_nxt.conv.diff     = s_r.ctrl[AIQ_CTRL_DIFF];
        s_nxt.conv.gain     = s_r.ctrl[AIQ_CTRL_GAIN_LSB +: 2];
        s_nxt.conv.range    = s_r.ctrl[AIQ_CTRL_RANGE_LSB +: 2];

        // Track trigger channel side for crossing detection.
        if (convDone && (s_r.conv.chan == s_r.trigChan)) begin
            s_nxt.aboveOk = levelAbove;
            s_nxt.belowOk = !levelAbove;
        end

        // Scanner advance on completion.
        if (convDone && s_r.busy) begin
            s_nxt.busy = 1'b0;
            if (s_r.ctrl[AIQ_CTRL_SCANEN]) begin
                s_nxt.conv.chan = aiq_next_chan(s_r.conv.chan, s_r.lastChan);
            end
        end

        if (fifoPush) begin
            s_nxt.wp = s_r.wp + 1'b1;
        end else if (convDone && s_r.busy && (s_r.st != AIQ_ARM)) begin
            s_nxt.overflow = 1'b1;
        end
        if (fifoPop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end

        // Sequencer.
        unique case (s_r.st)
            AIQ_IDLE: begin
                if (bus.wr && (bus.addr == AIQ_REG_CMD) && bus.wdata[AIQ_CMD_START]) begin
                    s_nxt.remain    = s_r.count;
                    s_nxt.conv.chan = '0;
                    s_nxt.aboveOk   = 1'b0;
                    s_nxt.belowOk   = 1'b0;
                    s_nxt.overflow  = convDone && s_r.busy && fifoFull;
                    if (startsOnTrig) begin
                        s_nxt.st = AIQ_ARM;
                        if (s_r.ctrl[AIQ_CTRL_ANATRIG]) begin
                            s_nxt.conv.chan = s_r.trigChan;
                        end
                    end else begin
                        s_nxt.st = AIQ_RUN;
                    end
                end
            end
            AIQ_ARM: begin
                // Analog arming needs the trigger channel sampled while waiting.
                if (paceTick && s_r.ctrl[AIQ_CTRL_ANATRIG] && !s_r.busy) begin
                    s_nxt.conv.start = 1'b1;
                    s_nxt.busy       = 1'b1;
                    s_nxt.conv.chan  = s_r.trigChan;
                end
                if (trigEvt) begin
                    s_nxt.st = AIQ_RUN;
                    if (s_r.ctrl[AIQ_CTRL_ANATRIG]) begin
                        s_nxt.conv.chan = s_r.trigChan;
                    end
                end
            end
            AIQ_RUN, AIQ_POST: begin
                if (paceTick && !s_r.busy) begin
                    s_nxt.conv.start = 1'b1;
                    s_nxt.busy       = 1'b1;
                end
                if ((mode == AIQ_SW_POSTTRIG) && (s_r.st == AIQ_RUN) && trigEvt) begin
                    s_nxt.st     = AIQ_POST;
                    s_nxt.remain = s_r.count;
                end
                if (fifoPush && (countsN || (s_r.st == AIQ_POST))) begin
                    s_nxt.remain = s_r.remain - 24'h000001;
                    if (s_r.remain <= 24'h000001) begin
                        s_nxt.st = AIQ_IDLE;
                    end
                end
            end
            default: s_nxt.st = AIQ_IDLE;
        endcase

        // Software stop works in every state.
        if (bus.wr && (bus.addr == AIQ_REG_CMD) && bus.wdata[AIQ_CMD_STOP]) begin
            s_nxt.st = AIQ_IDLE;
        end

        // Register reads, answered next cycle.
        if (bus.rd) begin
            unique case (bus.addr)
                AIQ_REG_CTRL:   s_nxt.rdata = s_r.ctrl;
                AIQ_REG_RATE:   s_nxt.rdata = {8'h00, s_r.rateDiv};
                AIQ_REG_COUNT:  s_nxt.rdata = {8'h00, s_r.count};
                AIQ_REG_SCAN:   s_nxt.rdata = {24'h000000, s_r.lastChan};
                AIQ_REG_TRIG:   s_nxt.rdata = {24'h000000, s_r.trigChan};
                AIQ_REG_STATUS: s_nxt.rdata = {8'h00, s_r.conv.chan, 10'h000, s_r.overflow,
                                               fifoFull, fifoEmpty, s_r.busy, s_r.st};
                AIQ_REG_REMAIN: s_nxt.rdata = {8'h00, s_r.remain};
                default:        s_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            s_r         <= '0;
            s_r.ctrl    <= AIQ_CTRL_RESET;
            s_r.rateDiv <= AIQ_RATE_RESET;
            s_r.count   <= AIQ_COUNT_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (fifoPush) begin
            fifoMem[s_r.wp[FIFO_AW-1:0]] <= convData;
        end
        fifoOut_r <= fifoMem[s_r.rp[FIFO_AW-1:0]];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    logic fifoRead_r;

    always_ff @(posedge mclk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            fifoRead_r <= 1'b0;
        end else begin
            fifoRead_r <= bus.rd && (bus.addr == AIQ_REG_FIFO);
        end
    end

    assign rdata        = fifoRead_r ? {20'h00000, fifoOut_r} : s_r.rdata;
    assign conv         = s_r.conv;
    assign rateOut      = s_r.rgOut;
    // Level is held negated; the host writes the desired level into the trigger word.
    assign trigLevelOwn = s_r.ctrl[AIQ_CTRL_ANATRIG];
    assign trigLevelNeg = s_r.trigLevel;

endmodule : aiq_sequencer

`default_nettype wire
